// *** include/ifs_pkg.sv ***
// Constants for the second interrupt flag status bank
package ifs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned LANE_W = 8;

  // Byte addresses on the register bus
  localparam logic [ADDR_W-1:0] FLAG_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 12'h004;

  // Flag positions
  localparam int unsigned PARALLEL_POS = 13;
  localparam int unsigned COMPARE5_POS = 9;
  localparam int unsigned CAPTURE5_POS = 7;
  localparam int unsigned CAPTURE4_POS = 6;
  localparam int unsigned CAPTURE3_POS = 5;
  localparam int unsigned SERIAL2_EVENT_POS = 1;
  localparam int unsigned SERIAL2_FAULT_POS = 0;

  // Implemented bits; all others read zero and ignore writes
  localparam logic [FLAG_W-1:0] IMPL_MASK = 16'h22e3;

  localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
endpackage

// *** rtl/ifs_flag_cell.sv ***
// One sticky interrupt request flag with set priority over software write
module ifs_flag_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic setEvent,
  input wire logic wrEn,
  input wire logic wrBit,
  output logic flag
);
  logic flagReg;
  logic flagNext;

  always_comb begin
    flagNext = flagReg;
    // Source event beats a same-cycle software clear
    if (setEvent) begin
      flagNext = 1'b1;
    end else if (wrEn) begin
      flagNext = wrBit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagReg <= 1'b0;
    end else begin
      flagReg <= flagNext;
    end
  end

  assign flag = flagReg;
endmodule

// *** rtl/ifs_flag_bank2.sv ***
// APB slave holding interrupt flag status bank 2 with mask and interrupt output
// Behaviour
// - Bit 13 holds parallel port request flag.
// - Bit 1 holds serial unit 2 event flag.
// - Compare5 bit 9, captures 7-5, fault bit 0.
// - Unimplemented bits read zero, ignore writes.
// - Flags read zero idle, writable, reset cleared.
module ifs_flag_bank2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ifs_pkg::ADDR_W-1:0] paddr,
  input wire logic [ifs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ifs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parallelPortReq,
  input wire logic compare5Req,
  input wire logic capture5Req,
  input wire logic capture4Req,
  input wire logic capture3Req,
  input wire logic serial2EventReq,
  input wire logic serial2FaultReq,
  output logic irq
);
  import ifs_pkg::*;

  logic setupPhase;
  logic accessPhase;
  logic hitFlag;
  logic hitMask;
  logic mapped;
  logic wrFlag;
  logic wrMask;
  logic [FLAG_W-1:0] eventVec;
  logic [FLAG_W-1:0] interruptFlagStatus2;
  logic [FLAG_W-1:0] maskReg;
  logic [FLAG_W-1:0] maskNext;
  logic [DATA_W-1:0] prdataReg;
  logic [DATA_W-1:0] prdataNext;
  logic [FLAG_W-1:0] laneEnable;
  logic parallelPortReqFlag;
  logic compare5ReqFlag;
  logic capture5ReqFlag;
  logic capture4ReqFlag;
  logic capture3ReqFlag;
  logic serial2EventReqFlag;
  logic serial2FaultReqFlag;

  // Bus decode
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign hitFlag = (paddr == FLAG_OFFSET);
  assign hitMask = (paddr == MASK_OFFSET);
  assign mapped = hitFlag || hitMask;
  // Writes land only at the completing access edge
  assign wrFlag = accessPhase && pwrite && hitFlag;
  assign wrMask = accessPhase && pwrite && hitMask;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;

  // Event sources placed at their flag positions
  always_comb begin
    eventVec = '0;
    eventVec[PARALLEL_POS] = parallelPortReq;
    eventVec[SERIAL2_EVENT_POS] = serial2EventReq;
    eventVec[COMPARE5_POS] = compare5Req;
    eventVec[CAPTURE5_POS] = capture5Req;
    eventVec[CAPTURE4_POS] = capture4Req;
    eventVec[CAPTURE3_POS] = capture3Req;
    eventVec[SERIAL2_FAULT_POS] = serial2FaultReq;
  end

  // Byte strobes guard each flag; a half-word write to the low lanes is enough
  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++) begin : g_bit
      assign laneEnable[i] = pstrb[i / LANE_W];
      if (IMPL_MASK[i]) begin : g_impl
        ifs_flag_cell u_cell (
          .clk(clk),
          .rst_n(rst_n),
          .setEvent(eventVec[i]),
          .wrEn(wrFlag && laneEnable[i]),
          .wrBit(pwdata[i]),
          .flag(interruptFlagStatus2[i])
        );
      end else begin : g_unimpl
        assign interruptFlagStatus2[i] = 1'b0;
      end
    end
  endgenerate

  assign parallelPortReqFlag = interruptFlagStatus2[PARALLEL_POS];
  assign compare5ReqFlag = interruptFlagStatus2[COMPARE5_POS];
  assign capture5ReqFlag = interruptFlagStatus2[CAPTURE5_POS];
  assign capture4ReqFlag = interruptFlagStatus2[CAPTURE4_POS];
  assign capture3ReqFlag = interruptFlagStatus2[CAPTURE3_POS];
  assign serial2EventReqFlag = interruptFlagStatus2[SERIAL2_EVENT_POS];
  assign serial2FaultReqFlag = interruptFlagStatus2[SERIAL2_FAULT_POS];

  // Mask register, same layout as the flags
  always_comb begin
    maskNext = maskReg;
    if (wrMask) begin
      for (int b = 0; b < FLAG_W; b++) begin
        if (laneEnable[b]) begin
          maskNext[b] = pwdata[b] && IMPL_MASK[b];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskReg <= MASK_RESET;
    end else begin
      maskReg <= maskNext;
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  always_comb begin
    prdataNext = prdataReg;
    if (setupPhase && !pwrite) begin
      if (hitFlag) begin
        prdataNext = {16'h0000, interruptFlagStatus2 & IMPL_MASK};
      end else if (hitMask) begin
        prdataNext = {16'h0000, maskReg};
      end else begin
        prdataNext = RDATA_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdataReg <= RDATA_RESET;
    end else begin
      prdataReg <= prdataNext;
    end
  end

  assign prdata = prdataReg;

  // Level output; stays high until every unmasked flag is cleared
  assign irq = |(interruptFlagStatus2 & maskReg);

  a_parallel_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    parallelPortReq |=> parallelPortReqFlag
  ) else $error("parallel port event did not set bit 13");

  a_serial_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    serial2EventReq |=> serial2EventReqFlag && interruptFlagStatus2[1]
  ) else $error("serial event did not set bit 1");

  a_other_positions: assert property (
    @(posedge clk) disable iff (!rst_n)
    {compare5Req, capture5Req, capture4Req, capture3Req, serial2FaultReq} != 5'h00
    |=> ((interruptFlagStatus2 & $past(eventVec)) == $past(eventVec))
        && (compare5ReqFlag || !$past(compare5Req))
        && (capture5ReqFlag || !$past(capture5Req))
        && (capture4ReqFlag || !$past(capture4Req))
        && (capture3ReqFlag || !$past(capture3Req))
        && (serial2FaultReqFlag || !$past(serial2FaultReq))
  ) else $error("request flag not set at its position");

  a_unimpl_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((interruptFlagStatus2 & ~IMPL_MASK) == 16'h0000)
    && ((maskReg & ~IMPL_MASK) == 16'h0000)
    && (prdata[31:16] == 16'h0000)
    && ((prdata[15:0] & ~IMPL_MASK) == 16'h0000)
  ) else $error("unimplemented bit reads nonzero");

  a_read_value: assert property (
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitFlag)
    |=> prdata == {16'h0000, $past(interruptFlagStatus2)}
  ) else $error("flag read returned wrong value");

  a_write_value: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrFlag && pstrb[1:0] == 2'h3 && eventVec == 16'h0000)
    |=> interruptFlagStatus2 == ($past(pwdata[15:0]) & IMPL_MASK)
  ) else $error("flag write did not store value");

  a_set_wins: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrFlag && eventVec != 16'h0000)
    |=> (interruptFlagStatus2 & $past(eventVec)) == $past(eventVec)
  ) else $error("clear beat a same-cycle event");

  a_sticky_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wrFlag |=> (interruptFlagStatus2 & $past(interruptFlagStatus2))
                == $past(interruptFlagStatus2)
  ) else $error("flag dropped without software write");

  // An unmasked event must reach the pin one cycle later
  a_irq_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((eventVec & maskReg) != 16'h0000) && !wrMask |=> irq
  ) else $error("unmasked event did not raise the interrupt");

  a_irq_drop: assert property (
    @(posedge clk) disable iff (!rst_n)
    irq && (eventVec == 16'h0000) && wrFlag && (pstrb[1:0] == 2'h3)
    && (pwdata[15:0] == 16'h0000) |=> !irq
  ) else $error("interrupt stayed high after all flags were cleared");

  a_mask_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitMask)
    |=> prdata == {16'h0000, $past(maskReg)}
  ) else $error("mask read returned wrong value");
endmodule

// *** tb/ifs_event_src.sv ***
// Behavioural peripheral event sources that feed the flag bank
module ifs_event_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] fire,
  output logic parallelPortReq,
  output logic compare5Req,
  output logic capture5Req,
  output logic capture4Req,
  output logic capture3Req,
  output logic serial2EventReq,
  output logic serial2FaultReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] reqReg;
  // Registered so requests change just after an edge, as real event logic does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqReg <= 7'h00;
    end else begin
      reqReg <= fire;
    end
  end
  // A request held high keeps re-asserting its flag every cycle
  assign {parallelPortReq, compare5Req, capture5Req, capture4Req} = reqReg[6:3];
  assign {capture3Req, serial2EventReq, serial2FaultReq} = reqReg[2:0];
endmodule

// *** tb/ifs_flag_bank2_tb.sv ***
// Self-checking bench for the interrupt flag bank over APB
module ifs_flag_bank2_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ifs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready, irq, errBit;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rdData;
  logic [3:0] pstrb = 4'h0;
  logic [6:0] fire = 7'h00;
  logic [6:0] req;
  int numErrors = 0;
  int testsRun = 0;
  int unsigned posTab[7] = '{SERIAL2_FAULT_POS, SERIAL2_EVENT_POS, CAPTURE3_POS,
    CAPTURE4_POS, CAPTURE5_POS, COMPARE5_POS, PARALLEL_POS};

  always #2 clk = ~clk;

  ifs_event_src src_u (.clk(clk), .rst_n(rst_n), .fire(fire), .parallelPortReq(req[6]),
    .compare5Req(req[5]), .capture5Req(req[4]), .capture4Req(req[3]),
    .capture3Req(req[2]), .serial2EventReq(req[1]), .serial2FaultReq(req[0]));

  ifs_flag_bank2 dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parallelPortReq(req[6]), .compare5Req(req[5]),
    .capture5Req(req[4]), .capture4Req(req[3]), .capture3Req(req[2]),
    .serial2EventReq(req[1]), .serial2FaultReq(req[0]), .irq(irq));

  task final_report();
    if (numErrors == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data and error are taken at the edge that completes the access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdData = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      final_report();
    end
    // One idle edge so the next setup never reassigns psel in this time step
    @(posedge clk);
  endtask

  task pulse(input logic [6:0] v);
    fire <= v;
    repeat (3) @(posedge clk);
    fire <= 7'h00;
    @(posedge clk);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0);
    apb(1'b0, MASK_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0);
    apb(1'b1, MASK_OFFSET, 32'hffff_ffff, 4'hf);
    apb(1'b0, MASK_OFFSET, 32'h0, 4'h0); chk(rdData, {16'h0, IMPL_MASK});
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h1 << posTab[i]);
      apb(1'b1, FLAG_OFFSET, 32'h0, 4'h3);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1'b1, FLAG_OFFSET, 32'hffff_ffff, 4'hf);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, {16'h0, IMPL_MASK});
    // Low byte strobe only: the upper flag byte must survive the clearing write
    apb(1'b1, FLAG_OFFSET, 32'h0, 4'h1);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0000_2200);
    apb(1'b1, FLAG_OFFSET, 32'h0, 4'h3);
    fire <= 7'h40;
    repeat (2) @(posedge clk);
    apb(1'b1, FLAG_OFFSET, 32'h0, 4'h3);
    fire <= 7'h00;
    repeat (2) @(posedge clk);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0000_2000);
    apb(1'b1, FLAG_OFFSET, 32'h0, 4'h3);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'h0); chk({rdData[30:0], errBit}, 32'h1);
    // Mid-run reset must clear a set flag, the mask and the interrupt
    pulse(7'h01);
    chk({31'h0, irq}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0);
    apb(1'b0, MASK_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0);
    apb(1'b1, MASK_OFFSET, 32'h0, 4'hf);
    pulse(7'h20);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, FLAG_OFFSET, 32'h0, 4'h0); chk(rdData, 32'h0000_0200);
    final_report();
  end
endmodule
